/* rtl/adcsc_top.sv */
// How it works
// - Each result is found by successive approximation, ten bits wide.
// - Two modes exist; only single mode is built, the mode bit reads zero.
// - One write may change channel and set start; the new channel converts.
// - Single mode converts the selected channel once, then stops.
// - Start bit going to one begins conversion; software or external trigger sets it.
// - The result lands in the data register of the converted channel.
// - Each finished conversion sets the conversion end flag.
// - End flag with interrupt enable set raises the conversion end interrupt.
// - Start stays one while converting, clears itself at the end, back to idle.
// - Writing module stop one halts the converter when the bus cycle ends.
// - Writing module stop zero restarts the converter when the bus cycle ends.
// - The converter loses its internal state while stopped.
// - While stopped, converter register reads and writes are blocked.
// - After reset the converter sits in the stopped state.
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int SAMPLE = SAMPLE_CYCLES_DEF,
  parameter int SETTLE = SETTLE_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // avalon-mm slave
  input  wire logic [ADDR_BITS-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // pins
  input  wire logic                 ext_trigger,
  input  wire logic                 cmp_pin,
  // analog front end control
  output logic      [CH_BITS-1:0]   channel_select,
  output logic                      sample_hold,
  output logic      [RES_BITS-1:0]  dac_trial,
  // interrupts and status
  output logic                      conversion_end_interrupt,
  output logic                      irq,
  output logic                      module_stopped
);

  if (NUM_CH < 1 || NUM_CH > (1 << CH_BITS)) $error("adcsc_top: NUM_CH out of range");

  typedef enum logic {CTL_IDLE, CTL_CONVERT} adcsc_ctl_mode_type;

  typedef struct packed {
    logic                             ack;
    logic [31:0]                      rdata;
    logic                             module_stop_bit;
    logic [CH_BITS-1:0]               ch;
    logic                             trg_en;
    logic                             conversion_start_bit;
    logic                             conversion_end_irq_enable;
    logic                             conversion_end_flag;
    logic                             flag_seen;
    logic [NUM_CH-1:0][RES_BITS-1:0]  data;
    logic [IRQ_W-1:0]                 stat;
    logic [IRQ_W-1:0]                 mask;
    logic                             irq;
    logic                             cei;
    logic                             trig_prev;
    adcsc_ctl_mode_type               state;
    logic [CH_BITS-1:0]               conv_ch;
    logic                             go;
    logic                             abort;
  } adcsc_top_state_type;

  adcsc_top_state_type state_reg;
  adcsc_top_state_type state_next;

  logic                req;
  logic                access_end;
  logic                wr_ok;
  logic                rd_end;
  logic                conv_hit;
  logic                trig_s;
  logic                cmp_s;
  logic                trig_rise;
  logic                sar_done;
  logic [RES_BITS-1:0] sar_result;

  // a data register sits at each of the first NUM_CH aligned words from OFS_DATA0 on
  function automatic logic is_data_addr(input logic [ADDR_BITS-1:0] a);
    logic [ADDR_BITS-1:0] diff;
    diff = a - OFS_DATA0;
    return (a >= OFS_DATA0) && (a[1:0] == 2'b00) && (int'(diff[ADDR_BITS-1:2]) < NUM_CH);
  endfunction : is_data_addr

  function automatic logic [CH_BITS-1:0] data_index(input logic [ADDR_BITS-1:0] a);
    logic [ADDR_BITS-1:0] diff;
    diff = a - OFS_DATA0;
    return diff[CH_BITS+1:2];
  endfunction : data_index

  function automatic logic [7:0] csr_image(input adcsc_top_state_type s);
    logic [7:0] v;
    v = CSR_RESET;
    v[CSR_CH_LSB +: CH_BITS] = s.ch;
    v[CSR_TRG_BIT]           = s.trg_en;
    v[CSR_MODE_BIT]          = 1'b0; // scan mode is not built here
    v[CSR_START_BIT]         = s.conversion_start_bit;
    v[CSR_IE_BIT]            = s.conversion_end_irq_enable;
    v[CSR_END_BIT]           = s.conversion_end_flag;
    return v;
  endfunction : csr_image

  adcsc_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({ext_trigger, cmp_pin}),
    .sync_out ({trig_s, cmp_s})
  );

  adcsc_sar #(
    .RES    (RES_BITS),
    .SAMPLE (SAMPLE),
    .SETTLE (SETTLE)
  ) u_sar (
    .clk      (clk),
    .rst      (rst),
    .go       (state_reg.go),
    .abort    (state_reg.abort),
    .cmp_high (cmp_s),
    .hold     (sample_hold),
    .trial    (dac_trial),
    .done     (sar_done),
    .result   (sar_result)
  );

  assign req        = avs_read | avs_write;
  assign access_end = req & state_reg.ack;
  assign wr_ok      = avs_write & state_reg.ack & avs_byteenable[0];
  assign rd_end     = avs_read & state_reg.ack;
  assign conv_hit   = (avs_address == OFS_CSR) || is_data_addr(avs_address);
  assign trig_rise  = trig_s & ~state_reg.trig_prev;

  always_comb begin
    state_next       = state_reg;
    state_next.go    = 1'b0;
    state_next.abort = 1'b0;
    // one wait cycle, then the access completes
    state_next.ack   = req & ~state_reg.ack;
    state_next.trig_prev = trig_s;

    // read data is captured in the wait cycle and stands at completion
    if (req && !state_reg.ack) begin
      state_next.rdata = '0;
      if (avs_read) begin
        if (avs_address == OFS_STOP) begin
          state_next.rdata[STOP_BIT] = state_reg.module_stop_bit;
        end else if (avs_address == OFS_IRQ_STAT) begin
          state_next.rdata[IRQ_W-1:0] = state_reg.stat;
        end else if (avs_address == OFS_IRQ_MASK) begin
          state_next.rdata[IRQ_W-1:0] = state_reg.mask;
        end else if (state_reg.module_stop_bit) begin
          state_next.rdata = '0;
        end else if (avs_address == OFS_CSR) begin
          state_next.rdata[7:0] = csr_image(state_reg);
        end else if (is_data_addr(avs_address)) begin
          state_next.rdata[RES_BITS-1:0] = state_reg.data[data_index(avs_address)];
        end
      end
    end

    // reads and writes of the stopped converter are refused
    if (access_end && conv_hit && state_reg.module_stop_bit) begin
      state_next.stat[IRQ_DENIED_BIT] = 1'b1;
    end

    // read of the status register clears only what that read returned
    if (rd_end && avs_address == OFS_IRQ_STAT) begin
      state_next.stat = state_reg.stat & ~state_reg.rdata[IRQ_W-1:0];
      if (conv_hit && state_reg.module_stop_bit) begin
        state_next.stat[IRQ_DENIED_BIT] = 1'b1;
      end
    end

    if (rd_end && avs_address == OFS_CSR && !state_reg.module_stop_bit) begin
      if (state_reg.rdata[CSR_END_BIT]) begin
        state_next.flag_seen = 1'b1;
      end
    end

    if (wr_ok) begin
      if (avs_address == OFS_STOP) begin
        // takes effect at the edge that ends the bus cycle
        state_next.module_stop_bit = avs_writedata[STOP_BIT];
      end else if (avs_address == OFS_IRQ_MASK) begin
        state_next.mask = avs_writedata[IRQ_W-1:0];
      end else if (avs_address == OFS_CSR && !state_reg.module_stop_bit) begin
        // channel and start may change in the same write
        state_next.ch                        = avs_writedata[CSR_CH_LSB +: CH_BITS];
        state_next.trg_en                    = avs_writedata[CSR_TRG_BIT];
        state_next.conversion_end_irq_enable = avs_writedata[CSR_IE_BIT];
        state_next.conversion_start_bit      = avs_writedata[CSR_START_BIT];
        if (!avs_writedata[CSR_END_BIT] && state_reg.flag_seen) begin
          state_next.conversion_end_flag = 1'b0;
          state_next.flag_seen           = 1'b0;
        end
      end
    end

    // the external trigger sets the start bit on its rising edge
    if (trig_rise && state_reg.trg_en && !state_reg.module_stop_bit) begin
      if (state_reg.state == CTL_IDLE) begin
        state_next.conversion_start_bit = 1'b1;
      end else begin
        state_next.stat[IRQ_TRIG_LOST_BIT] = 1'b1;
      end
    end

    unique case (state_reg.state)
      CTL_IDLE: begin
        if (state_next.conversion_start_bit) begin
          // channel is frozen here, later channel writes wait for the next start
          state_next.state   = CTL_CONVERT;
          state_next.conv_ch = state_next.ch;
          state_next.go      = 1'b1;
        end
      end
      CTL_CONVERT: begin
        if (sar_done) begin
          state_next.data[state_reg.conv_ch] = sar_result;
          state_next.conversion_end_flag     = 1'b1;
          state_next.flag_seen               = 1'b0;
          state_next.stat[IRQ_DONE_BIT]      = 1'b1;
          state_next.conversion_start_bit    = 1'b0;
          state_next.state                   = CTL_IDLE;
        end else if (!state_next.conversion_start_bit) begin
          // software cleared start mid-conversion, result is dropped
          state_next.abort = 1'b1;
          state_next.state = CTL_IDLE;
        end
      end
    endcase

    // a stopped converter keeps nothing
    if (state_next.module_stop_bit) begin
      state_next.ch                        = CSR_RESET[CSR_CH_LSB +: CH_BITS];
      state_next.trg_en                    = CSR_RESET[CSR_TRG_BIT];
      state_next.conversion_start_bit      = CSR_RESET[CSR_START_BIT];
      state_next.conversion_end_irq_enable = CSR_RESET[CSR_IE_BIT];
      state_next.conversion_end_flag       = CSR_RESET[CSR_END_BIT];
      state_next.flag_seen                 = 1'b0;
      state_next.data                      = '0;
      state_next.state                     = CTL_IDLE;
      state_next.conv_ch                   = '0;
      state_next.go                        = 1'b0;
      state_next.abort                     = 1'b1;
    end

    state_next.cei = state_next.conversion_end_flag & state_next.conversion_end_irq_enable;
    state_next.irq = |(state_next.stat & state_next.mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg                 <= '0;
      state_reg.stat            <= IRQ_STAT_RESET;
      state_reg.mask            <= IRQ_MASK_RESET;
      state_reg.module_stop_bit <= STOP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // handshake is combinational, every data output is a flip-flop
  assign avs_waitrequest          = req & ~state_reg.ack;
  assign avs_readdata             = state_reg.rdata;
  assign channel_select           = state_reg.conv_ch;
  assign conversion_end_interrupt = state_reg.cei;
  assign irq                      = state_reg.irq;
  assign module_stopped           = state_reg.module_stop_bit;

endmodule : adcsc_top

/* include/adcsc_pkg.sv */
package adcsc_pkg;

  // converter geometry
  localparam int RES_BITS   = 10;
  localparam int CH_BITS    = 3;
  localparam int NUM_CH_DEF = 8;
  localparam int ADDR_BITS  = 8;

  // byte offsets on the register bus
  localparam logic [ADDR_BITS-1:0] OFS_CSR      = 8'h00;
  localparam logic [ADDR_BITS-1:0] OFS_DATA0    = 8'h04;
  localparam logic [ADDR_BITS-1:0] OFS_STOP     = 8'h40;
  localparam logic [ADDR_BITS-1:0] OFS_IRQ_STAT = 8'h44;
  localparam logic [ADDR_BITS-1:0] OFS_IRQ_MASK = 8'h48;

  // converter_control_status_reg fields
  localparam int CSR_CH_LSB    = 0;
  localparam int CSR_TRG_BIT   = 3;
  localparam int CSR_MODE_BIT  = 4;
  localparam int CSR_START_BIT = 5;
  localparam int CSR_IE_BIT    = 6;
  localparam int CSR_END_BIT   = 7;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // module_stop_control_reg fields
  localparam int   STOP_BIT   = 0;
  localparam logic STOP_RESET = 1'b1;

  // interrupt status and mask layout
  localparam int IRQ_W             = 3;
  localparam int IRQ_DONE_BIT      = 0;
  localparam int IRQ_DENIED_BIT    = 1;
  localparam int IRQ_TRIG_LOST_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // conversion timing in clock cycles
  localparam int SAMPLE_CYCLES_DEF = 8;
  localparam int SETTLE_CYCLES_DEF = 4;
  localparam int SYNC_LATENCY      = 2;

endpackage : adcsc_pkg

/* rtl/adcsc_sync.sv */
module adcsc_sync
  import adcsc_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } adcsc_sync_state_type;

  adcsc_sync_state_type state_reg;
  adcsc_sync_state_type state_next;

  // the first stage feeds the second stage only
  always_comb begin
    state_next      = state_reg;
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.sync;

endmodule : adcsc_sync

/* rtl/adcsc_sar.sv */
module adcsc_sar
  import adcsc_pkg::*;
#(
  parameter int RES    = RES_BITS,
  parameter int SAMPLE = SAMPLE_CYCLES_DEF,
  parameter int SETTLE = SETTLE_CYCLES_DEF
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // control from the sequencer
  input  wire logic           go,
  input  wire logic           abort,
  // analog side
  input  wire logic           cmp_high,
  output logic                hold,
  output logic [RES-1:0]      trial,
  // result
  output logic                done,
  output logic [RES-1:0]      result
);

  if (RES < 2 || RES > 16) $error("adcsc_sar: RES out of range");
  if (SAMPLE < 1 || SAMPLE > 256) $error("adcsc_sar: SAMPLE out of range");
  // the comparator passes a synchroniser, so the answer lags the trial word
  if (SETTLE <= SYNC_LATENCY || SETTLE > 256) $error("adcsc_sar: SETTLE too short");

  localparam logic [7:0] SAMPLE_CNT = 8'(SAMPLE - 1);
  localparam logic [7:0] SETTLE_CNT = 8'(SETTLE - 1);
  localparam logic [3:0] TOP_IDX    = 4'(RES - 1);

  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_BIT} adcsc_sar_mode_type;

  typedef struct packed {
    adcsc_sar_mode_type state;
    logic [7:0]         cnt;
    logic [3:0]         idx;
    logic [RES-1:0]     acc;
    logic [RES-1:0]     result;
    logic               done;
    logic               hold;
  } adcsc_sar_state_type;

  adcsc_sar_state_type state_reg;
  adcsc_sar_state_type state_next;
  logic [3:0]          idx_down;

  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    idx_down        = state_reg.idx - 4'h1;
    unique case (state_reg.state)
      SAR_IDLE: begin
        if (go) begin
          state_next.state = SAR_SAMPLE;
          state_next.cnt   = SAMPLE_CNT;
          state_next.acc   = '0;
          state_next.hold  = 1'b0;
        end
      end
      SAR_SAMPLE: begin
        if (state_reg.cnt == 8'h00) begin
          state_next.state          = SAR_BIT;
          state_next.hold           = 1'b1;
          state_next.idx            = TOP_IDX;
          state_next.acc            = '0;
          state_next.acc[TOP_IDX]   = 1'b1;
          state_next.cnt            = SETTLE_CNT;
        end else begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
      SAR_BIT: begin
        if (state_reg.cnt == 8'h00) begin
          // keep the trial bit only if the input is at or above the trial level
          if (!cmp_high) begin
            state_next.acc[state_reg.idx] = 1'b0;
          end
          if (state_reg.idx == 4'h0) begin
            state_next.result = state_next.acc;
            state_next.done   = 1'b1;
            state_next.state  = SAR_IDLE;
            state_next.hold   = 1'b0;
          end else begin
            state_next.idx           = idx_down;
            state_next.acc[idx_down] = 1'b1;
            state_next.cnt           = SETTLE_CNT;
          end
        end else begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
    endcase
    // an abort leaves no trial word behind, so a stopped converter shows nothing
    if (abort) begin
      state_next = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hold   = state_reg.hold;
  assign trial  = state_reg.acc;
  assign done   = state_reg.done;
  assign result = state_reg.result;

endmodule : adcsc_sar

/* sim/adcsc_analog.sv */
module adcsc_analog
  import adcsc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // front end control from the converter
  input  wire logic [CH_BITS-1:0]    channel_select,
  input  wire logic                  sample_hold,
  input  wire logic [RES_BITS-1:0]   dac_trial,
  // analog levels, one code per channel
  input  wire logic [8*RES_BITS-1:0] vin_flat,
  // comparator
  output logic                       cmp_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RES_BITS-1:0] held;
  // tracks while sampling and freezes in hold, so a moving input cannot corrupt trials
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= '0;
    end else if (!sample_hold) begin
      held <= vin_flat[channel_select*RES_BITS +: RES_BITS];
    end
  end
  assign cmp_pin = (held >= dac_trial);
endmodule : adcsc_analog

/* sim/adcsc_checker.sv */
module adcsc_checker
  import adcsc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register bus
  input  wire logic [ADDR_BITS-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [31:0]          avs_readdata,
  input  wire logic                 avs_waitrequest,
  // converter side
  input  wire logic                 ext_trigger,
  input  wire logic [CH_BITS-1:0]   channel_select,
  input  wire logic                 sample_hold,
  input  wire logic [RES_BITS-1:0]  dac_trial,
  input  wire logic                 conversion_end_interrupt,
  input  wire logic                 irq,
  input  wire logic                 module_stopped
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic done_acc;
  assign req = avs_read | avs_write;
  assign done_acc = req & ~avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bus_one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access took more than one wait cycle");
  stop_write_a: assert property (done_acc && avs_write && avs_address == OFS_STOP &&
    avs_byteenable[0] |=> module_stopped == $past(avs_writedata[0]))
    else $error("module stop did not follow the write");
  stop_after_reset_a: assert property ($past(rst) |-> module_stopped)
    else $error("converter not stopped after reset");
  stopped_read_zero_a: assert property (module_stopped && done_acc && avs_read &&
    avs_address < OFS_STOP |-> avs_readdata == 32'h0)
    else $error("blocked register returned data");
  stopped_quiet_a: assert property (module_stopped && $past(module_stopped) |->
    !sample_hold && dac_trial == '0 && channel_select == '0 && !conversion_end_interrupt)
    else $error("converter active while stopped");
  first_trial_a: assert property ($rose(sample_hold) |-> dac_trial == 10'h200)
    else $error("first trial is not mid scale");
  upper_zero_a: assert property (done_acc && avs_read |-> avs_readdata[31:10] == 22'h0)
    else $error("read data wider than ten bits");
  channel_hold_a: assert property (sample_hold && !module_stopped |->
    $stable(channel_select))
    else $error("channel moved during conversion");
  irq_after_end_a: assert property ($rose(conversion_end_interrupt) |-> !sample_hold)
    else $error("end interrupt during bit trials");
  end_irq_c: cover property ($rose(conversion_end_interrupt));
  resume_c: cover property ($fell(module_stopped));
  trigger_c: cover property ($rose(ext_trigger) ##[1:20] $rose(sample_hold));
endmodule : adcsc_checker

bind adcsc_top adcsc_checker adcsc_checker_i (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ext_trigger(ext_trigger), .channel_select(channel_select), .sample_hold(sample_hold),
  .dac_trial(dac_trial), .conversion_end_interrupt(conversion_end_interrupt),
  .irq(irq), .module_stopped(module_stopped)
);

/* sim/adcsc_top_test.sv */
module adcsc_top_test
  import adcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk, rst, avs_read, avs_write, ext_trigger, cmp_pin;
  logic [ADDR_BITS-1:0]  avs_address;
  logic [3:0]            avs_byteenable;
  logic [31:0]           avs_writedata, avs_readdata, q;
  logic                  avs_waitrequest, sample_hold, conversion_end_interrupt, irq;
  logic                  module_stopped;
  logic [CH_BITS-1:0]    channel_select;
  logic [RES_BITS-1:0]   dac_trial, val;
  logic [8*RES_BITS-1:0] vin_flat;
  logic [31:0]           exp_data [8];
  logic [IRQ_W-1:0]      exp_stat;
  int                    err_total, comparisons, cycles;

  adcsc_top #(.NUM_CH(8), .SAMPLE(1), .SETTLE(3)) adcsc_top_i (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_trigger(ext_trigger), .cmp_pin(cmp_pin), .channel_select(channel_select),
    .sample_hold(sample_hold), .dac_trial(dac_trial),
    .conversion_end_interrupt(conversion_end_interrupt), .irq(irq),
    .module_stopped(module_stopped));
  adcsc_analog adcsc_analog_i (
    .clk(clk), .rst(rst), .channel_select(channel_select), .sample_hold(sample_hold),
    .dac_trial(dac_trial), .vin_flat(vin_flat), .cmp_pin(cmp_pin));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low; only the global timeout ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd_chk

  task automatic conv(input int ch, input logic trg);
    logic [31:0] c;
    int n;
    c = 32'h40 | (trg ? 32'h8 : 32'h0) | 32'(ch);
    if (!trg) bus(1'b1, OFS_CSR, c | 32'h20);
    else begin
      bus(1'b1, OFS_CSR, c);
      ext_trigger <= 1'b1;
      repeat (4) @(posedge clk);
      ext_trigger <= 1'b0;
    end
    rd_chk(OFS_CSR, c | 32'h20);
    n = 0;
    while (conversion_end_interrupt !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(conversion_end_interrupt, 1'b1);
    exp_data[ch] = 32'(vin_flat[ch*RES_BITS +: RES_BITS]);
    exp_stat[IRQ_DONE_BIT] = 1'b1;
    rd_chk(OFS_DATA0 + 8'(4*ch), exp_data[ch]);
    rd_chk(OFS_DATA0 + 8'(4*((ch+1)%8)), exp_data[(ch+1)%8]);
    rd_chk(OFS_CSR, c | 32'h80);
    check(irq, 1'b1);
    rd_chk(OFS_IRQ_STAT, 32'(exp_stat));
    exp_stat = '0;
    bus(1'b1, OFS_CSR, c);
    rd_chk(OFS_CSR, c);
    check(irq, 1'b0);
    check(conversion_end_interrupt, 1'b0);
  endtask : conv

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write, ext_trigger} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    vin_flat = '0;
    exp_stat = '0;
    foreach (exp_data[i]) exp_data[i] = 32'h0;
    void'($urandom(32'hfe4705ab));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check(module_stopped, 1'b1);
    rd_chk(OFS_STOP, 32'h1);
    bus(1'b1, OFS_CSR, 32'h21);
    rd_chk(OFS_CSR, 32'h0);
    exp_stat[IRQ_DENIED_BIT] = 1'b1;
    rd_chk(8'h30, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    rd_chk(OFS_IRQ_MASK, 32'h1);
    rd_chk(OFS_IRQ_STAT, 32'(exp_stat));
    exp_stat = '0;
    bus(1'b1, OFS_STOP, 32'h0);
    rd_chk(OFS_STOP, 32'h0);
    check(module_stopped, 1'b0);
    for (int i = 0; i < 8; i++) begin
      // extremes of the code range on the first and last channel
      val = (i == 0) ? 10'h000 : (i == 7) ? 10'h3ff : RES_BITS'($urandom);
      vin_flat[i*RES_BITS +: RES_BITS] <= val;
      conv(i, i == 3 || i == 6);
    end
    // trigger while busy is refused, then clearing start drops the running conversion
    bus(1'b1, OFS_CSR, 32'h2a);
    ext_trigger <= 1'b1;
    repeat (4) @(posedge clk);
    ext_trigger <= 1'b0;
    exp_stat[IRQ_TRIG_LOST_BIT] = 1'b1;
    bus(1'b1, OFS_CSR, 32'h0a);
    repeat (40) @(posedge clk);
    rd_chk(OFS_CSR, 32'h0a);
    rd_chk(OFS_DATA0 + 8'h8, exp_data[2]);
    bus(1'b1, OFS_CSR, 32'h22);
    bus(1'b1, OFS_STOP, 32'h1);
    rd_chk(OFS_STOP, 32'h1);
    check(module_stopped, 1'b1);
    rd_chk(OFS_DATA0 + 8'h8, 32'h0);
    exp_stat[IRQ_DENIED_BIT] = 1'b1;
    bus(1'b1, OFS_STOP, 32'h0);
    rd_chk(OFS_DATA0 + 8'h4, 32'h0);
    rd_chk(OFS_CSR, 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'(exp_stat));
    end_sim();
  end
endmodule : adcsc_top_test
